// ---- verilog/rdi_pkg.sv ----
// Constants, field positions and carrier types for the receive alarm interrupt block.
// Assumes a single 50 MHz system clock and a synchronous active-low reset.
//----------------------------------------------------------------------
// Behaviour
// - Enable register holds eight read/write source enables
// - One enables a source, zero blocks it
// - Signal loss interrupts on declare and clear
// - Enabled event drives request pin low
// - Signal loss change sets status bit 6
// - Frame loss change sets status bit 1
// - Status flags mirror enables, clear on read
// - Config/status bit 6 shows live signal loss
// - Config/status bit 4 shows live frame loss
// - Bits 7,5 live, 3 reserved, 2..0 writable
// - Frame loss at 3/6 errors in 16 bits
// - Frame loss clears on multiframe search to in-frame
// - Frame loss interrupts on declare and clear
// - Send far-end failure while signal loss lasts
// - Signal loss from line input or zero run
// - Block-level receive enable also gates request pin
//----------------------------------------------------------------------
package rdi_pkg;

  // Register word indices (byte address is four times the index)
  localparam logic [7:0] RDI_IDX_BLK_EN = 8'h04;
  localparam logic [7:0] RDI_IDX_CFG_STAT = 8'h10;
  localparam logic [7:0] RDI_IDX_IRQ_EN = 8'h12;
  localparam logic [7:0] RDI_IDX_IRQ_STAT = 8'h13;
  localparam logic [7:0] RDI_IDX_LINE_CFG = 8'h00;

  // Source bit positions shared by enable and status
  localparam int RDI_BIT_CPERR = 7;
  localparam int RDI_BIT_LOSS = 6;
  localparam int RDI_BIT_AIS = 5;
  localparam int RDI_BIT_IDLE = 4;
  localparam int RDI_BIT_FAR_END_FAILURE = 3;
  localparam int RDI_BIT_AIC = 2;
  localparam int RDI_BIT_FRAME = 1;
  localparam int RDI_BIT_PERR = 0;

  // Config/status live bit positions
  localparam int RDI_CS_AIS = 7;
  localparam int RDI_CS_LOSS = 6;
  localparam int RDI_CS_IDLE = 5;
  localparam int RDI_CS_FRAME = 4;
  localparam logic [7:0] RDI_CS_WR_MASK = 8'h07;

  // Block enable and line config bit positions
  localparam int RDI_BLK_RX_EN = 7;
  localparam int RDI_LINE_INT_LOSS = 5;

  // Reset values
  localparam logic [7:0] RDI_RST_IRQ_EN = 8'h00;
  localparam logic [7:0] RDI_RST_CTRL = 8'h00;

  // Frame loss and signal loss criteria
  localparam int RDI_FBIT_WIN = 16;
  localparam int RDI_FERR_LO = 3;
  localparam int RDI_FERR_HI = 6;
  localparam int RDI_ZERO_RUN = 180;
  localparam int RDI_MARK_WIN = 180;
  localparam int RDI_MARK_MIN = 60;

  // Frame acquisition states
  typedef enum logic [1:0] {
    RDI_ST_FSEARCH,
    RDI_ST_MSEARCH,
    RDI_ST_INFRAME
  } rdi_frm_st_t;

  // Receive-side event inputs from the framer
  typedef struct packed {
    logic line_iface_loss_in; // Loss from line interface
    logic bit_valid; // One received bit period
    logic bit_mark; // Mark seen in that period
    logic fbit_valid; // Framing bit checked
    logic fbit_err; // Framing bit wrong
    logic fsync_found; // F-bit alignment found
    logic msync_found; // Multiframe alignment found
    logic alarm_signal_state; // Live alarm indication
    logic idle_pattern_state; // Live idle pattern
    logic far_end_failure_state; // Live far-end failure
    logic app_id_channel_chg; // Channel bit changed
    logic pbit_err; // Parity error pulse
    logic cpbit_err; // CP-bit error pulse
  } rdi_rx_ev_t;

endpackage

// ---- verilog/rdi_rx_irq.sv ----
// Receive alarm interrupt block: signal loss, frame loss, status and request pin.
// Assumes an Avalon-MM master on the system clock and framer events synchronous to it.
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ps
module rdi_rx_irq (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // Avalon-MM slave
  input wire logic [9:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Framer events
  input wire rdi_pkg::rdi_rx_ev_t i_rx_ev,
  // Outputs toward host and transmitter
  output logic o_irq_n,
  output logic o_far_end_failure_send,
  output logic o_signal_lost_state,
  output logic o_frame_lost_state
);
  import rdi_pkg::*;

  //--------------------------------------------------------------------
  // Helpers
  //--------------------------------------------------------------------
  // Count ones in a 16-bit window
  function automatic logic [4:0] rdi_ones16(input logic [15:0] v);
    logic [4:0] n;
    n = 5'h00;
    for (int k = 0; k < 16; k++) begin
      n = n + {4'h0, v[k]};
    end
    return n;
  endfunction

  //--------------------------------------------------------------------
  // Registers
  //--------------------------------------------------------------------
  logic [7:0] irq_en_r; // Source enables
  logic [7:0] irq_stat_r; // Latched flags
  logic [2:0] cs_ctrl_r; // Writable config bits
  logic blk_en_r; // Block receive enable
  logic int_loss_en_r; // Internal loss detect enable
  logic ack_r; // Bus answer pending
  logic wait_r; // Waitrequest, high unless answering
  logic [31:0] rdata_r; // Bus read data
  logic irq_n_r; // Request pin
  logic far_end_failure_r; // Far-end failure send

  //--------------------------------------------------------------------
  // Bus decode
  //--------------------------------------------------------------------
  wire [7:0] idx = i_avs_address[9:2]; // Word index
  wire req = (i_avs_read | i_avs_write) & ~ack_r; // New request
  wire wr_go = i_avs_write & ack_r; // Write commits at answer edge
  wire rd_go = i_avs_read & ~ack_r; // Read captured one cycle early
  wire wr_lo = wr_go & i_avs_byteenable[0]; // Low lane written
  wire [7:0] wd = i_avs_writedata[7:0];
  wire hit_cs = idx == RDI_IDX_CFG_STAT;
  wire hit_en = idx == RDI_IDX_IRQ_EN;
  wire hit_st = idx == RDI_IDX_IRQ_STAT;
  wire hit_blk = idx == RDI_IDX_BLK_EN;
  wire hit_line = idx == RDI_IDX_LINE_CFG;
  wire stat_rd = rd_go & hit_st; // Read clears status

  //--------------------------------------------------------------------
  // Signal loss detection
  //--------------------------------------------------------------------
  logic [7:0] zero_cnt_r; // Consecutive zero count
  logic [7:0] win_cnt_r; // Bit periods in mark window
  logic [7:0] mark_cnt_r; // Marks in window
  logic int_loss_r; // Internal loss state
  logic loss_r; // Combined loss state
  logic loss_d_r; // Loss previous cycle

  wire zero_hit = i_rx_ev.bit_valid & ~i_rx_ev.bit_mark &
                  (zero_cnt_r == 8'(RDI_ZERO_RUN - 1)); // Run completes
  wire win_end = i_rx_ev.bit_valid & (win_cnt_r == 8'(RDI_MARK_WIN - 1));
  wire [7:0] marks_now = mark_cnt_r + {7'h00, i_rx_ev.bit_mark};
  wire mark_ok = win_end & (marks_now >= 8'(RDI_MARK_MIN)); // Density met
  wire loss_nxt = i_rx_ev.line_iface_loss_in | (int_loss_en_r & int_loss_r);

  // Zero run and mark window counters
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      zero_cnt_r <= 8'h00;
      win_cnt_r <= 8'h00;
      mark_cnt_r <= 8'h00;
      int_loss_r <= 1'b0;
    end else if (i_rx_ev.bit_valid) begin
      zero_cnt_r <= (i_rx_ev.bit_mark | zero_hit) ? 8'h00 : zero_cnt_r + 8'h01;
      win_cnt_r <= win_end ? 8'h00 : win_cnt_r + 8'h01;
      mark_cnt_r <= win_end ? 8'h00 : marks_now;
      if (zero_hit) begin
        int_loss_r <= 1'b1;
      end else if (mark_ok) begin
        int_loss_r <= 1'b0;
      end
    end
  end

  //--------------------------------------------------------------------
  // Frame loss detection and acquisition
  //--------------------------------------------------------------------
  logic [15:0] fhist_r; // Last 16 F-bit results
  rdi_frm_st_t frm_st_r; // Acquisition state
  rdi_frm_st_t frm_st_nxt;
  logic frame_loss_r; // Live frame loss
  logic frame_d_r; // Frame loss previous cycle

  wire [15:0] fhist_nxt = {fhist_r[14:0], i_rx_ev.fbit_err};
  wire [4:0] ferr_cnt = rdi_ones16(fhist_nxt);
  wire [4:0] ferr_lim = cs_ctrl_r[1] ? 5'(RDI_FERR_HI) : 5'(RDI_FERR_LO); // Sync select
  wire ferr_trip = i_rx_ev.fbit_valid & (ferr_cnt >= ferr_lim);
  wire to_inframe = (frm_st_r == RDI_ST_MSEARCH) & i_rx_ev.msync_found;

  // Next acquisition state
  always_comb begin
    frm_st_nxt = frm_st_r;
    unique case (frm_st_r)
      RDI_ST_FSEARCH: begin
        if (i_rx_ev.fsync_found) begin
          frm_st_nxt = RDI_ST_MSEARCH;
        end
      end
      RDI_ST_MSEARCH: begin
        if (i_rx_ev.msync_found) begin
          frm_st_nxt = RDI_ST_INFRAME;
        end
      end
      RDI_ST_INFRAME: begin
        if (ferr_trip) begin
          frm_st_nxt = RDI_ST_FSEARCH;
        end
      end
      // Unused code falls back to search
      default: begin
        frm_st_nxt = RDI_ST_FSEARCH;
      end
    endcase
  end

  // F-bit history, state and frame loss flag
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      fhist_r <= 16'h0000;
      frm_st_r <= RDI_ST_FSEARCH;
      frame_loss_r <= 1'b1;
    end else begin
      if (i_rx_ev.fbit_valid) begin
        fhist_r <= (ferr_trip || frm_st_r != RDI_ST_INFRAME) ? 16'h0000 : fhist_nxt;
      end
      frm_st_r <= frm_st_nxt;
      if (frm_st_r == RDI_ST_INFRAME && ferr_trip) begin
        frame_loss_r <= 1'b1;
      end else if (to_inframe) begin
        frame_loss_r <= 1'b0;
      end
    end
  end

  //--------------------------------------------------------------------
  // Change detection and status flags
  //--------------------------------------------------------------------
  logic ais_d_r, idle_d_r, far_end_failure_d_r; // Previous live states
  wire [7:0] ev_vec; // Per-source events
  assign ev_vec[RDI_BIT_CPERR] = i_rx_ev.cpbit_err;
  assign ev_vec[RDI_BIT_LOSS] = loss_r ^ loss_d_r;
  assign ev_vec[RDI_BIT_AIS] = i_rx_ev.alarm_signal_state ^ ais_d_r;
  assign ev_vec[RDI_BIT_IDLE] = i_rx_ev.idle_pattern_state ^ idle_d_r;
  assign ev_vec[RDI_BIT_FAR_END_FAILURE] = i_rx_ev.far_end_failure_state ^ far_end_failure_d_r;
  assign ev_vec[RDI_BIT_AIC] = i_rx_ev.app_id_channel_chg;
  assign ev_vec[RDI_BIT_FRAME] = frame_loss_r ^ frame_d_r;
  assign ev_vec[RDI_BIT_PERR] = i_rx_ev.pbit_err;
  wire [7:0] set_vec = ev_vec & irq_en_r;
  // Set wins over read clear
  wire [7:0] stat_nxt = (stat_rd ? 8'h00 : irq_stat_r) | set_vec;
  wire irq_pend = blk_en_r & (|(stat_nxt & irq_en_r));

  // Live state tracking and flags
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      loss_r <= 1'b0;
      loss_d_r <= 1'b0;
      frame_d_r <= 1'b1;
      ais_d_r <= 1'b0;
      idle_d_r <= 1'b0;
      far_end_failure_d_r <= 1'b0;
      irq_stat_r <= 8'h00;
      irq_n_r <= 1'b1;
      far_end_failure_r <= 1'b0;
    end else begin
      loss_r <= loss_nxt;
      loss_d_r <= loss_r;
      frame_d_r <= frame_loss_r;
      ais_d_r <= i_rx_ev.alarm_signal_state;
      idle_d_r <= i_rx_ev.idle_pattern_state;
      far_end_failure_d_r <= i_rx_ev.far_end_failure_state;
      irq_stat_r <= stat_nxt;
      irq_n_r <= ~irq_pend;
      far_end_failure_r <= loss_r;
    end
  end

  //--------------------------------------------------------------------
  // Register file and bus answer
  //--------------------------------------------------------------------
  wire [7:0] cs_val = {i_rx_ev.alarm_signal_state, loss_r, i_rx_ev.idle_pattern_state,
                       frame_loss_r, 1'b0, cs_ctrl_r};
  wire [7:0] rd_mux = hit_cs ? cs_val :
                      hit_en ? irq_en_r :
                      hit_st ? irq_stat_r :
                      hit_blk ? {blk_en_r, 7'h00} :
                      hit_line ? {2'b00, int_loss_en_r, 5'h00} : 8'h00;

  // Writes, read capture and waitrequest
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      irq_en_r <= RDI_RST_IRQ_EN;
      cs_ctrl_r <= RDI_RST_CTRL[2:0];
      blk_en_r <= 1'b0;
      int_loss_en_r <= 1'b0;
      ack_r <= 1'b0;
      wait_r <= 1'b1;
      rdata_r <= 32'h00000000;
    end else begin
      ack_r <= req;
      wait_r <= ~req; // Low for the answer cycle only
      if (rd_go) begin
        rdata_r <= {24'h000000, rd_mux};
      end
      if (wr_lo && hit_en) begin
        irq_en_r <= wd;
      end
      if (wr_lo && hit_cs) begin
        cs_ctrl_r <= wd[2:0] & RDI_CS_WR_MASK[2:0];
      end
      if (wr_lo && hit_blk) begin
        blk_en_r <= wd[RDI_BLK_RX_EN];
      end
      if (wr_lo && hit_line) begin
        int_loss_en_r <= wd[RDI_LINE_INT_LOSS];
      end
    end
  end

  //--------------------------------------------------------------------
  // Outputs
  //--------------------------------------------------------------------
  assign o_avs_readdata = rdata_r;
  assign o_avs_waitrequest = wait_r;
  assign o_irq_n = irq_n_r;
  assign o_far_end_failure_send = far_end_failure_r;
  assign o_signal_lost_state = loss_r;
  assign o_frame_lost_state = frame_loss_r;

endmodule

// ---- tb/rdi_rx_irq_props.sv ----
// Checker for the receive alarm interrupt block, bound to its ports.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module rdi_rx_irq_props (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic [9:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire rdi_pkg::rdi_rx_ev_t i_rx_ev,
  input wire logic o_irq_n,
  input wire logic o_far_end_failure_send,
  input wire logic o_signal_lost_state,
  input wire logic o_frame_lost_state
);
  import rdi_pkg::*;
  // Shadow copies of the enables, from taken writes
  logic [7:0] en_r;
  logic blk_r;
  wire logic [7:0] idx = i_avs_address[9:2];
  wire logic wr_ok = i_avs_write & ~o_avs_waitrequest & i_avs_byteenable[0];
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      en_r <= 8'h00;
      blk_r <= 1'b0;
    end else if (wr_ok) begin
      if (idx == RDI_IDX_IRQ_EN) en_r <= i_avs_writedata[7:0];
      if (idx == RDI_IDX_BLK_EN) blk_r <= i_avs_writedata[7];
    end
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  a_fef_follow: assert property (o_far_end_failure_send == $past(o_signal_lost_state))
    else $error("far-end send not following loss");
  a_line_loss: assert property (i_rx_ev.line_iface_loss_in |=> o_signal_lost_state)
    else $error("line loss not declared");
  a_loss_irq: assert property ($changed(o_signal_lost_state) && en_r[6] && blk_r |=> !o_irq_n)
    else $error("no request on loss change");
  a_frame_irq: assert property ($changed(o_frame_lost_state) && en_r[1] && blk_r |=> !o_irq_n)
    else $error("no request on frame change");
  a_blk_gate: assert property (!blk_r && !$past(blk_r) |-> o_irq_n)
    else $error("request with block disabled");
  a_mask_all: assert property (en_r == 8'h00 && $past(en_r) == 8'h00 |-> o_irq_n)
    else $error("request with all sources masked");
  a_live_read: assert property (!o_avs_waitrequest && $past(i_avs_read)
    && $past(idx) == RDI_IDX_CFG_STAT |-> o_avs_readdata[6] == $past(o_signal_lost_state)
    && o_avs_readdata[4] == $past(o_frame_lost_state)) else $error("live flags wrong");
  a_wait_once: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest ##1 o_avs_waitrequest) else $error("bad answer timing");
  c_loss_set: cover property ($rose(o_signal_lost_state));
  c_frame_clr: cover property ($fell(o_frame_lost_state));
  c_irq_low: cover property ($fell(o_irq_n));
endmodule

bind rdi_rx_irq rdi_rx_irq_props i_rdi_rx_irq_props (.*);

// ---- tb/rdi_host.sv ----
// Host model: Avalon-MM master for register access.
// Assumes the slave answers by dropping waitrequest.
`timescale 1ns/1ps
module rdi_host (
  input wire logic i_clk_sys,
  input wire logic i_wait,
  output logic [9:0] o_addr,
  output logic o_rd,
  output logic o_wr,
  output logic [31:0] o_wdata,
  output logic [3:0] o_be
);
  initial begin
    {o_rd, o_wr, o_addr, o_wdata, o_be} = '0;
  end
  // One access, held until waitrequest is seen low
  task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] d,
                     input logic [3:0] be = 4'h1);
    @(posedge i_clk_sys);
    o_addr <= {idx, 2'b00};
    o_rd <= !w;
    o_wr <= w;
    o_wdata <= {24'h000000, d};
    o_be <= be;
    do @(posedge i_clk_sys); while (i_wait !== 1'b0);
    {o_rd, o_wr} <= 2'b00;
    // Released address and data lines show the inverse, never stale values
    o_addr <= ~o_addr;
    o_wdata <= ~o_wdata;
  endtask
endmodule

// ---- tb/rdi_rx_irq_tb.sv ----
// Self-checking bench for the receive alarm interrupt block.
// Assumes the host model drives the bus and the checker is bound.
`timescale 1ns/1ps
module rdi_rx_irq_tb;
  import rdi_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_nrst = 1'b0;
  logic [9:0] adr;
  logic [31:0] wd, rdat;
  logic [3:0] be;
  logic rd, wr, wq, irq_n, fef, sl, fl;
  rdi_rx_ev_t ev = '0;
  int miscompares = 0;
  int total_checks = 0;
  int cyc = 0;
  int alarm_msgs = 0; // Alarm messages the host sends
  int seed = 32'hd72b327c;
  logic [15:0] exp_q[$];
  logic [15:0] e;
  logic [7:0] r;
  always #10 i_clk_sys = ~i_clk_sys;
  rdi_rx_irq i_rdi_rx_irq (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wq), .i_rx_ev(ev), .o_irq_n(irq_n),
    .o_far_end_failure_send(fef), .o_signal_lost_state(sl), .o_frame_lost_state(fl));
  rdi_host i_rdi_host (.i_clk_sys(i_clk_sys), .i_wait(wq), .o_addr(adr), .o_rd(rd),
    .o_wr(wr), .o_wdata(wd), .o_be(be));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Reads note {mask, value} for the watcher
  task automatic rdx(input logic [7:0] idx, input logic [7:0] m, input logic [7:0] x);
    exp_q.push_back({m, x});
    i_rdi_host.acc(1'b0, idx, 8'h00);
  endtask
  task automatic wrx(input logic [7:0] idx, input logic [7:0] d);
    i_rdi_host.acc(1'b1, idx, d);
  endtask
  task automatic gap(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic bits(input int n, input logic m);
    repeat (n) begin
      @(posedge i_clk_sys);
      {ev.bit_valid, ev.bit_mark} <= {1'b1, m};
    end
    @(posedge i_clk_sys);
    ev.bit_valid <= 1'b0;
    gap(2);
  endtask
  task automatic fb(input int n, input logic err);
    repeat (n) begin
      @(posedge i_clk_sys);
      {ev.fbit_valid, ev.fbit_err} <= {1'b1, err};
      @(posedge i_clk_sys);
      ev.fbit_valid <= 1'b0;
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Watcher: each read answer against the oldest note
  always @(posedge i_clk_sys) begin
    if (rd && wq === 1'b0) begin
      e = exp_q.pop_front();
      chk(rdat[7:0] & e[15:8], e[7:0]);
    end
  end
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      end_of_test();
    end
  end
  initial begin
    repeat (4) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    rdx(RDI_IDX_IRQ_EN, 8'hff, RDI_RST_IRQ_EN);
    rdx(RDI_IDX_CFG_STAT, 8'hf7, 8'h10);
    rdx(8'h20, 8'hff, 8'h00);
    r = 8'($random(seed));
    wrx(RDI_IDX_IRQ_EN, r);
    rdx(RDI_IDX_IRQ_EN, 8'hff, r);
    // Write with lane 0 off leaves the enables alone
    i_rdi_host.acc(1'b1, RDI_IDX_IRQ_EN, ~r, 4'he);
    rdx(RDI_IDX_IRQ_EN, 8'hff, r);
    wrx(RDI_IDX_CFG_STAT, 8'hff);
    rdx(RDI_IDX_CFG_STAT, 8'hf7, 8'h17);
    $display("register test done");
    // Line loss: enabled, masked at source, masked at block
    for (int k = 0; k < 4; k++) begin
      wrx(RDI_IDX_IRQ_EN, (k == 2) ? 8'h02 : 8'h42);
      wrx(RDI_IDX_BLK_EN, (k == 3) ? 8'h00 : 8'h80);
      @(posedge i_clk_sys);
      ev.line_iface_loss_in <= !k[0];
      gap(3);
      chk(8'(irq_n), 8'(k > 1));
      chk(8'(fef), 8'(!k[0]));
      rdx(RDI_IDX_CFG_STAT, 8'h40, {1'b0, !k[0], 6'h00});
      // Host answers each loss change with one alarm message
      alarm_msgs++;
      // A masked source latches no flag
      rdx(RDI_IDX_IRQ_STAT, 8'hff, (k == 2) ? 8'h00 : 8'h40);
      rdx(RDI_IDX_IRQ_STAT, 8'hff, 8'h00);
      chk(8'(irq_n), 8'h01);
    end
    // Internal zero-run loss and mark recovery
    wrx(RDI_IDX_LINE_CFG, 8'h20);
    bits(179, 1'b0);
    chk(8'(sl), 8'h00);
    bits(1, 1'b0);
    chk(8'(sl), 8'h01);
    bits(360, 1'b1);
    chk(8'(sl), 8'h00);
    rdx(RDI_IDX_IRQ_STAT, 8'hff, 8'h40);
    wrx(RDI_IDX_LINE_CFG, 8'h00);
    $display("loss test done, %0d alarm messages sent", alarm_msgs);
    // Frame loss at 3 or 6 errors within 16 framing bits
    wrx(RDI_IDX_IRQ_EN, 8'h02);
    wrx(RDI_IDX_BLK_EN, 8'h80);
    for (int s = 0; s < 2; s++) begin
      wrx(RDI_IDX_CFG_STAT, 8'(s << 1));
      @(posedge i_clk_sys);
      ev.fsync_found <= 1'b1;
      @(posedge i_clk_sys);
      {ev.fsync_found, ev.msync_found} <= 2'b01;
      @(posedge i_clk_sys);
      ev.msync_found <= 1'b0;
      gap(2);
      chk(8'(fl), 8'h00);
      rdx(RDI_IDX_IRQ_STAT, 8'hff, 8'h02);
      repeat (2) begin
        fb(s ? 5 : 2, 1'b1);
        fb(16, 1'b0);
      end
      fb(s ? 5 : 2, 1'b1);
      gap(2);
      chk(8'(fl), 8'h00);
      fb(1, 1'b1);
      gap(2);
      chk(8'(fl), 8'h01);
      chk(8'(irq_n), 8'h00);
      rdx(RDI_IDX_IRQ_STAT, 8'hff, 8'h02);
    end
    $display("frame test done");
    // Remaining sources latch in their own positions
    wrx(RDI_IDX_IRQ_EN, 8'hff);
    @(posedge i_clk_sys);
    ev <= 13'h003f;
    @(posedge i_clk_sys);
    ev <= 13'h0038;
    gap(2);
    rdx(RDI_IDX_CFG_STAT, 8'ha0, 8'ha0);
    rdx(RDI_IDX_IRQ_STAT, 8'hff, 8'hbd);
    ev <= 13'h0000;
    gap(3);
    rdx(RDI_IDX_IRQ_STAT, 8'hff, 8'h38);
    $display("source test done");
    gap(2);
    end_of_test();
  end
endmodule
